// ### core/atc_defines.svh
// Register offsets, field positions, reset values and prescaler taps of the timer 0 control block
`ifndef ATC_DEFINES_SVH
`define ATC_DEFINES_SVH

// ----------------------------------------------------------------
// Register word indexes (byte address = index * 4)
// ----------------------------------------------------------------
`define ATC_IDX_ASYNC_STATUS     6'h00
`define ATC_IDX_IRQ_MASK         6'h01
`define ATC_IDX_IRQ_FLAGS        6'h02
`define ATC_IDX_GEN_CTRL         6'h03
`define ATC_IDX_COUNTER          6'h04
`define ATC_IDX_COMPARE_A        6'h05
`define ATC_IDX_CONTROL_A        6'h06
`define ATC_IDX_CONTROL_B        6'h07
`define ATC_IDX_LIMIT            6'h08

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define ATC_B_EXT_CLK_EN         6
`define ATC_B_ASYNC_SEL          5
`define ATC_B_SYNC_HOLD          7
`define ATC_B_PRESCALER_RESET_REQUEST               1
`define ATC_B_OTHER_PRESCALER_RESET_REQUEST               0
`define ATC_B_CMP_A              1
`define ATC_B_OVF                0
`define ATC_CTRL_A_MASK          8'hC3
`define ATC_CTRL_B_CS_W          3

// ----------------------------------------------------------------
// Reset values, bus answers and counter limits
// ----------------------------------------------------------------
`define ATC_RST_BYTE             8'h00
`define ATC_RESP_OKAY            2'h0
`define ATC_RESP_SLVERR          2'h2
`define ATC_CNT_MAX              8'hFF
`define ATC_CNT_BOTTOM           8'h00
`define ATC_CNT_ONE              8'h01

// ----------------------------------------------------------------
// Prescaler tap masks: a tap fires when all masked bits are one
// ----------------------------------------------------------------
`define ATC_PS_DIV1              10'h000
`define ATC_PS_DIV8              10'h007
`define ATC_PS_DIV32             10'h01F
`define ATC_PS_DIV64             10'h03F
`define ATC_PS_DIV128            10'h07F
`define ATC_PS_DIV256            10'h0FF
`define ATC_PS_DIV1024           10'h3FF

`endif

// ### core/atc_pkg.sv
// Types shared by the timer 0 control block and its helpers
package atc_pkg;

	// Bus state machine, one-hot
	typedef enum logic [3:0] {
		ST_IDLE = 4'h1,
		ST_RACC = 4'h2,
		ST_WRSP = 4'h4,
		ST_RRSP = 4'h8
	} atc_bus_e;

	// Waveform generation modes
	typedef enum logic [1:0] {
		WGM_NORMAL = 2'h0,
		WGM_PCPWM  = 2'h1,
		WGM_CTC    = 2'h2,
		WGM_FAST   = 2'h3
	} atc_wgm_e;

	typedef struct packed {
		atc_bus_e   state;
		logic       awready;
		logic       wready;
		logic       arready;
		logic       bvalid;
		logic       rvalid;
		logic [1:0] bresp;
		logic [1:0] rresp;
		logic [7:0] rdata;
		logic       aw_got;
		logic       w_got;
		logic [5:0] waddr;
		logic [7:0] wdata;
		logic       wstrb0;
		logic       ext_en;
		logic       async_sel;
		logic       cnt_busy;
		logic       cmp_busy;
		logic       ctla_busy;
		logic       ctlb_busy;
		logic       cmp_ie;
		logic       ovf_ie;
		logic       cmp_flag;
		logic       ovf_flag;
		logic       sync_hold_mode;
		logic       prescaler_reset_request;
		logic       other_prescaler_reset_request;
		logic [7:0] cnt;
		logic [7:0] cmp;
		logic [7:0] ctla;
		logic [2:0] ctlb;
		logic [7:0] cnt_tmp;
		logic [7:0] cmp_tmp;
		logic [7:0] ctla_tmp;
		logic [2:0] ctlb_tmp;
		logic       down;
		logic       block;
		logic       ext_buf;
		logic       osc_run;
		logic       cmp_irq;
		logic       ovf_irq;
	} atc_state_s;

	typedef struct packed {
		logic meta;
		logic sync;
		logic prev;
	} atc_sync_s;

	typedef struct packed {
		logic [9:0] cnt;
	} atc_pre_s;

endpackage : atc_pkg

// ### core/atc_edge_sync.sv
// Two-stage synchroniser with rising-edge detector for the asynchronous timer clock
module atc_edge_sync (
	// Clock and reset
	input  wire logic i_clk,
	input  wire logic i_nrst,
	// Sampled clock source
	input  wire logic i_pin,
	// Rising edge, one cycle
	output logic      o_rise
);
	atc_pkg::atc_sync_s s_r;
	atc_pkg::atc_sync_s s_nxt;

	always_comb
	begin
		s_nxt.meta = i_pin;
		s_nxt.sync = s_r.meta;
		s_nxt.prev = s_r.sync;
	end

	always_ff @(posedge i_clk or negedge i_nrst)
	begin
		if (!i_nrst)
			s_r <= '0;
		else
			s_r <= s_nxt;
	end

	assign o_rise = s_r.sync & ~s_r.prev;
endmodule : atc_edge_sync

// ### core/atc_prescaler.sv
// Ten-bit timer prescaler with reset and clock-select taps
`include "atc_defines.svh"
module atc_prescaler (
	// Clock and reset
	input  wire logic       i_clk,
	input  wire logic       i_nrst,
	// Source tick, reset hold and tap select
	input  wire logic       i_tick,
	input  wire logic       i_clear,
	input  wire logic [2:0] i_sel,
	// Timer tick
	output logic            o_tick
);
	atc_pkg::atc_pre_s s_r;
	atc_pkg::atc_pre_s s_nxt;
	logic [9:0]        mask;

	always_comb
	begin
		case (i_sel)
			3'h1: mask = `ATC_PS_DIV1;
			3'h2: mask = `ATC_PS_DIV8;
			3'h3: mask = `ATC_PS_DIV32;
			3'h4: mask = `ATC_PS_DIV64;
			3'h5: mask = `ATC_PS_DIV128;
			3'h6: mask = `ATC_PS_DIV256;
			default: mask = `ATC_PS_DIV1024;
		endcase
		s_nxt = s_r;
		if (i_clear)
			s_nxt.cnt = '0;
		else if (i_tick)
			s_nxt.cnt = s_r.cnt + 10'h001;
	end

	always_ff @(posedge i_clk or negedge i_nrst)
	begin
		if (!i_nrst)
			s_r <= '0;
		else
			s_r <= s_nxt;
	end

	// Stopped when no source is selected or while held in reset
	assign o_tick = i_tick & ~i_clear & (i_sel != 3'h0) & ((s_r.cnt & mask) == mask);
endmodule : atc_prescaler

// ### core/atc_timer0_ctrl.sv
// Timer 0 control: clock selection, update-busy handshakes, interrupt flags, prescaler reset, AXI4-Lite registers
//
// The AXI4-Lite register port and the register offsets were decided locally.
`include "atc_defines.svh"
module atc_timer0_ctrl (
	// Clock and reset
	input  wire logic        i_clk,
	input  wire logic        i_nrst,
	// AXI4-Lite write channels
	input  wire logic [7:0]  i_awaddr,
	input  wire logic        i_awvalid,
	output logic             o_awready,
	input  wire logic [31:0] i_wdata,
	input  wire logic [3:0]  i_wstrb,
	input  wire logic        i_wvalid,
	output logic             o_wready,
	output logic [1:0]       o_bresp,
	output logic             o_bvalid,
	input  wire logic        i_bready,
	// AXI4-Lite read channels
	input  wire logic [7:0]  i_araddr,
	input  wire logic        i_arvalid,
	output logic             o_arready,
	output logic [31:0]      o_rdata,
	output logic [1:0]       o_rresp,
	output logic             o_rvalid,
	input  wire logic        i_rready,
	// Clock sources and system clock status
	input  wire logic        i_lf_crystal_clk,
	input  wire logic        i_oscillator_input_pin,
	input  wire logic        i_sysclk_internal_osc,
	// CPU interrupt side
	input  wire logic        i_global_irq_en,
	input  wire logic        i_cmp_vector_ack,
	input  wire logic        i_ovf_vector_ack,
	// Clock control and timer status
	output logic             o_ext_clk_buf_en,
	output logic             o_lf_osc_run,
	output logic             o_timer_async,
	output logic [7:0]       o_counter_value,
	output logic             o_other_prescaler_reset,
	// Interrupt requests
	output logic             o_cmp_irq,
	output logic             o_ovf_irq
);
	atc_pkg::atc_state_s s;
	atc_pkg::atc_state_s n;
	logic                aw_hs;
	logic                w_hs;
	logic                wr_en;
	logic [7:0]          d;
	logic                async_edge;
	logic                src_tick;
	logic                tmr_tick;
	logic                cmp_set;
	logic                ovf_set;
	logic [5:0]          ridx;

	// ----------------------------------------------------------------
	// Clock source synchroniser and prescaler
	// ----------------------------------------------------------------
	atc_edge_sync u_sync (
		.i_clk  (i_clk),
		.i_nrst (i_nrst),
		.i_pin  (s.ext_en ? i_oscillator_input_pin : i_lf_crystal_clk),
		.o_rise (async_edge)
	);

	assign src_tick = s.async_sel ? async_edge : 1'b1;

	atc_prescaler u_pre (
		.i_clk   (i_clk),
		.i_nrst  (i_nrst),
		.i_tick  (src_tick),
		.i_clear (s.prescaler_reset_request),
		.i_sel   (s.ctlb),
		.o_tick  (tmr_tick)
	);

	// ----------------------------------------------------------------
	// Read data
	// ----------------------------------------------------------------
	function automatic logic [7:0] rd_mux(input atc_pkg::atc_state_s st, input logic [5:0] idx);
		case (idx)
			`ATC_IDX_ASYNC_STATUS: rd_mux = {1'b0, st.ext_en, st.async_sel, st.cnt_busy, st.cmp_busy,
				1'b0, st.ctla_busy, st.ctlb_busy};
			`ATC_IDX_IRQ_MASK:     rd_mux = {6'h00, st.cmp_ie, st.ovf_ie};
			`ATC_IDX_IRQ_FLAGS:    rd_mux = {6'h00, st.cmp_flag, st.ovf_flag};
			`ATC_IDX_GEN_CTRL:     rd_mux = {st.sync_hold_mode, 5'h00, st.prescaler_reset_request, st.other_prescaler_reset_request};
			`ATC_IDX_COUNTER:      rd_mux = st.cnt;
			`ATC_IDX_COMPARE_A:    rd_mux = st.cmp_tmp;
			`ATC_IDX_CONTROL_A:    rd_mux = st.ctla_tmp;
			`ATC_IDX_CONTROL_B:    rd_mux = {5'h00, st.ctlb_tmp};
			default:               rd_mux = `ATC_RST_BYTE;
		endcase
	endfunction : rd_mux

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb
	begin
		n = s;
		wr_en = 1'b0;
		cmp_set = 1'b0;
		ovf_set = 1'b0;
		aw_hs = i_awvalid & s.awready;
		w_hs = i_wvalid & s.wready;
		ridx = i_araddr[7:2];
		// Bus handshakes
		case (s.state)
			atc_pkg::ST_IDLE:
			begin
				if (aw_hs)
				begin
					n.aw_got = 1'b1;
					n.waddr = i_awaddr[7:2];
				end
				if (w_hs)
				begin
					n.w_got = 1'b1;
					n.wdata = i_wdata[7:0];
					n.wstrb0 = i_wstrb[0];
				end
				if (n.aw_got && n.w_got)
				begin
					wr_en = n.wstrb0 && (n.waddr < `ATC_IDX_LIMIT);
					n.aw_got = 1'b0;
					n.w_got = 1'b0;
					n.bvalid = 1'b1;
					n.bresp = (n.waddr < `ATC_IDX_LIMIT) ? `ATC_RESP_OKAY : `ATC_RESP_SLVERR;
					n.state = atc_pkg::ST_WRSP;
				end
				else if (!n.aw_got && !n.w_got && !i_awvalid && !i_wvalid && i_arvalid)
					n.state = atc_pkg::ST_RACC;
			end
			atc_pkg::ST_RACC:
			begin
				if (i_arvalid && s.arready)
				begin
					n.rdata = rd_mux(s, ridx);
					n.rresp = (ridx < `ATC_IDX_LIMIT) ? `ATC_RESP_OKAY : `ATC_RESP_SLVERR;
					n.rvalid = 1'b1;
					n.state = atc_pkg::ST_RRSP;
				end
			end
			atc_pkg::ST_WRSP:
			begin
				if (i_bready)
				begin
					n.bvalid = 1'b0;
					n.state = atc_pkg::ST_IDLE;
				end
			end
			atc_pkg::ST_RRSP:
			begin
				if (i_rready)
				begin
					n.rvalid = 1'b0;
					n.state = atc_pkg::ST_IDLE;
				end
			end
			default:
				n.state = atc_pkg::ST_IDLE;
		endcase
		n.awready = (n.state == atc_pkg::ST_IDLE) && !n.aw_got;
		n.wready = (n.state == atc_pkg::ST_IDLE) && !n.w_got;
		n.arready = (n.state == atc_pkg::ST_RACC);
		d = n.wdata;

		// Counting on each timer tick
		if (tmr_tick)
		begin
			cmp_set = !s.block && (s.cnt == s.cmp);
			n.block = 1'b0;
			case (atc_pkg::atc_wgm_e'(s.ctla[1:0]))
				atc_pkg::WGM_PCPWM:
				begin
					if (!s.down)
					begin
						n.cnt = s.cnt + `ATC_CNT_ONE;
						n.down = (s.cnt == `ATC_CNT_MAX) ? 1'b1 : 1'b0;
						if (s.cnt == `ATC_CNT_MAX)
							n.cnt = s.cnt - `ATC_CNT_ONE;
					end
					else if (s.cnt == `ATC_CNT_BOTTOM)
					begin
						n.down = 1'b0;
						n.cnt = `ATC_CNT_ONE;
						ovf_set = 1'b1;
					end
					else
						n.cnt = s.cnt - `ATC_CNT_ONE;
				end
				atc_pkg::WGM_CTC:
				begin
					n.cnt = (s.cnt == s.cmp) ? `ATC_CNT_BOTTOM : s.cnt + `ATC_CNT_ONE;
					ovf_set = (s.cnt == `ATC_CNT_MAX);
				end
				default:
				begin
					n.cnt = s.cnt + `ATC_CNT_ONE;
					ovf_set = (s.cnt == `ATC_CNT_MAX);
				end
			endcase
		end

		// Load of pending values on a synchronised timer clock edge
		if (s.async_sel && async_edge)
		begin
			if (s.cnt_busy)
			begin
				n.cnt = s.cnt_tmp;
				n.block = 1'b1;
			end
			if (s.cmp_busy)
				n.cmp = s.cmp_tmp;
			if (s.ctla_busy)
				n.ctla = s.ctla_tmp;
			if (s.ctlb_busy)
				n.ctlb = s.ctlb_tmp;
			n.cnt_busy = 1'b0;
			n.cmp_busy = 1'b0;
			n.ctla_busy = 1'b0;
			n.ctlb_busy = 1'b0;
		end

		// Hardware clear of prescaler reset requests
		if (!s.sync_hold_mode)
		begin
			if (!s.async_sel || async_edge)
				n.prescaler_reset_request = 1'b0;
			n.other_prescaler_reset_request = 1'b0;
		end

		// Flag clear by vector; set wins below
		if (i_cmp_vector_ack)
			n.cmp_flag = 1'b0;
		if (i_ovf_vector_ack)
			n.ovf_flag = 1'b0;

		// Software writes
		if (wr_en)
		begin
			case (n.waddr)
				`ATC_IDX_ASYNC_STATUS:
				begin
					n.ext_en = d[`ATC_B_EXT_CLK_EN];
					n.async_sel = d[`ATC_B_ASYNC_SEL] & i_sysclk_internal_osc;
				end
				`ATC_IDX_IRQ_MASK:
				begin
					n.cmp_ie = d[`ATC_B_CMP_A];
					n.ovf_ie = d[`ATC_B_OVF];
				end
				`ATC_IDX_IRQ_FLAGS:
				begin
					if (d[`ATC_B_CMP_A])
						n.cmp_flag = 1'b0;
					if (d[`ATC_B_OVF])
						n.ovf_flag = 1'b0;
				end
				`ATC_IDX_GEN_CTRL:
				begin
					n.sync_hold_mode = d[`ATC_B_SYNC_HOLD];
					n.prescaler_reset_request = d[`ATC_B_PRESCALER_RESET_REQUEST];
					n.other_prescaler_reset_request = d[`ATC_B_OTHER_PRESCALER_RESET_REQUEST];
				end
				`ATC_IDX_COUNTER:
				begin
					n.cnt_tmp = d;
					if (s.async_sel)
						n.cnt_busy = 1'b1;
					else
					begin
						n.cnt = d;
						n.block = 1'b1;
					end
				end
				`ATC_IDX_COMPARE_A:
				begin
					n.cmp_tmp = d;
					if (s.async_sel)
						n.cmp_busy = 1'b1;
					else
						n.cmp = d;
				end
				`ATC_IDX_CONTROL_A:
				begin
					n.ctla_tmp = d & `ATC_CTRL_A_MASK;
					if (s.async_sel)
						n.ctla_busy = 1'b1;
					else
						n.ctla = d & `ATC_CTRL_A_MASK;
				end
				`ATC_IDX_CONTROL_B:
				begin
					n.ctlb_tmp = d[`ATC_CTRL_B_CS_W-1:0];
					if (s.async_sel)
						n.ctlb_busy = 1'b1;
					else
						n.ctlb = d[`ATC_CTRL_B_CS_W-1:0];
				end
				default:
					n.ctlb_tmp = s.ctlb_tmp;
			endcase
		end

		// Hardware events win over any clear in the same cycle
		if (cmp_set)
			n.cmp_flag = 1'b1;
		if (ovf_set)
			n.ovf_flag = 1'b1;

		n.cmp_irq = s.cmp_ie & i_global_irq_en & s.cmp_flag;
		n.ovf_irq = s.ovf_ie & i_global_irq_en & s.ovf_flag;
		n.ext_buf = n.ext_en & n.async_sel;
		n.osc_run = ~n.ext_en & n.async_sel;
	end

	always_ff @(posedge i_clk or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			s <= '0;
			s.state <= atc_pkg::ST_IDLE;
		end
		else
			s <= n;
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign o_awready = s.awready;
	assign o_wready = s.wready;
	assign o_bresp = s.bresp;
	assign o_bvalid = s.bvalid;
	assign o_arready = s.arready;
	assign o_rdata = {24'h00_0000, s.rdata};
	assign o_rresp = s.rresp;
	assign o_rvalid = s.rvalid;
	assign o_ext_clk_buf_en = s.ext_buf;
	assign o_lf_osc_run = s.osc_run;
	assign o_timer_async = s.async_sel;
	assign o_counter_value = s.cnt;
	assign o_other_prescaler_reset = s.other_prescaler_reset_request;
	assign o_cmp_irq = s.cmp_irq;
	assign o_ovf_irq = s.ovf_irq;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (!i_nrst);

	logic wr_stat;
	logic wr_gen;
	assign wr_stat = wr_en && (n.waddr == `ATC_IDX_ASYNC_STATUS);
	assign wr_gen = wr_en && (n.waddr == `ATC_IDX_GEN_CTRL);

	sequence busy_wait;
		s.cmp_busy && !wr_en ##1 (s.async_sel && async_edge);
	endsequence

	a_ext_buf_osc: assert property (o_ext_clk_buf_en |-> !o_lf_osc_run && o_timer_async)
		else $error("external buffer on without asynchronous select or with oscillator");
	a_osc_only_zero: assert property (o_lf_osc_run |-> !s.ext_en)
		else $error("crystal oscillator runs with external clock enabled");
	a_select_forced: assert property ((wr_stat && !i_sysclk_internal_osc) |=> !o_timer_async)
		else $error("asynchronous select kept without internal system oscillator");
	a_cnt_busy_set: assert property ((wr_en && n.waddr == `ATC_IDX_COUNTER && s.async_sel) |=> s.cnt_busy)
		else $error("counter busy not set on asynchronous write");
	a_cmp_busy_drop: assert property (busy_wait |=> !s.cmp_busy && s.cmp == $past(s.cmp_tmp))
		else $error("compare busy did not drop with load");
	a_ctl_sync_write: assert property ((wr_en && n.waddr == `ATC_IDX_CONTROL_A && !s.async_sel) |=> !s.ctla_busy)
		else $error("control A busy set in synchronous mode");
	a_read_counter: assert property ((s.state == atc_pkg::ST_RACC && i_arvalid && ridx == `ATC_IDX_COUNTER)
		|=> o_rvalid && o_rdata[7:0] == $past(s.cnt))
		else $error("counter read did not return live value");
	a_cmp_irq_req: assert property ((s.cmp_ie && i_global_irq_en && s.cmp_flag) |=> o_cmp_irq)
		else $error("compare interrupt not requested");
	a_ovf_irq_req: assert property (o_ovf_irq |-> $past(s.ovf_ie && i_global_irq_en && s.ovf_flag))
		else $error("overflow interrupt without cause");
	a_cmp_flag_set: assert property ((tmr_tick && !s.block && s.cnt == s.cmp) |=> s.cmp_flag)
		else $error("compare match did not set flag");
	a_ovf_bottom: assert property ((tmr_tick && s.ctla[1:0] == 2'h1 && s.down && s.cnt == `ATC_CNT_BOTTOM)
		|=> s.ovf_flag && !s.down)
		else $error("phase correct turnaround did not set overflow");
	a_psr_sync_clr: assert property ((s.prescaler_reset_request && !s.async_sel && !s.sync_hold_mode && !wr_gen) |=> !s.prescaler_reset_request)
		else $error("prescaler reset not cleared in synchronous mode");
	a_psr_async_hold: assert property ((s.prescaler_reset_request && s.async_sel && !async_edge && !wr_gen) |=> s.prescaler_reset_request)
		else $error("prescaler reset dropped before timer clock edge");
	a_psr_tsm_hold: assert property ((s.prescaler_reset_request && s.sync_hold_mode && !wr_gen) [*2] |=> s.prescaler_reset_request)
		else $error("prescaler reset cleared in hold mode");
	a_tsm_release: assert property ((wr_gen && s.sync_hold_mode && n.wdata[7] == 1'b0 && n.wdata[1:0] == 2'h0)
		|=> !s.prescaler_reset_request && !s.other_prescaler_reset_request && !s.sync_hold_mode)
		else $error("hold release did not clear reset bits");
endmodule : atc_timer0_ctrl

// ### verif/atc_osc_model.sv
// Slow crystal and external clock sources for the timer 0 control block
module atc_osc_model #(
	parameter int HALF_NS = 110
) (
	// Run control
	input  wire logic i_run,
	// Clock sources
	output logic      o_xtal,
	output logic      o_ext
);
	timeunit 1ns;
	timeprecision 1ps;

	initial o_xtal = 1'b0;
	initial o_ext = 1'b0;

	// Well below half the I/O clock rate; both stand low while stopped
	always #(HALF_NS) o_xtal = i_run ? ~o_xtal : 1'b0;
	always #(HALF_NS + 13) o_ext = i_run ? ~o_ext : 1'b0;
endmodule : atc_osc_model

// ### verif/async_timer0_control_test.sv
// Self-checking bench for the timer 0 control block
module async_timer0_control_test;
	timeunit 1ns;
	timeprecision 1ps;

	typedef struct packed {
		logic       wr;
		logic [7:0] addr;
		logic [7:0] data;
		logic [7:0] exp;
	} atc_row_s;

	logic        clk, nrst, awvalid, wvalid, arvalid, sysosc, gie, oack, cack, run;
	logic        awready, wready, bvalid, arready, rvalid, xtal, extp, ebuf, lfrun, tasync, opsr, cirq, oirq;
	logic [7:0]  awaddr, araddr, rdv, cnt;
	logic [31:0] wdata, rdata;
	logic [1:0]  bresp, rresp, rsp;
	logic [3:0]  strb;
	int          n_mismatch, checks_done;
	atc_row_s    rows [12];

	initial clk = 1'b0;
	always #12.5 clk = ~clk;

	atc_timer0_ctrl dut (
		.i_clk(clk), .i_nrst(nrst), .i_awaddr(awaddr), .i_awvalid(awvalid), .o_awready(awready),
		.i_wdata(wdata), .i_wstrb(strb), .i_wvalid(wvalid), .o_wready(wready), .o_bresp(bresp),
		.o_bvalid(bvalid), .i_bready(1'b1), .i_araddr(araddr), .i_arvalid(arvalid), .o_arready(arready),
		.o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid), .i_rready(1'b1), .i_lf_crystal_clk(xtal),
		.i_oscillator_input_pin(extp), .i_sysclk_internal_osc(sysosc), .i_global_irq_en(gie),
		.i_cmp_vector_ack(cack), .i_ovf_vector_ack(oack), .o_ext_clk_buf_en(ebuf), .o_lf_osc_run(lfrun),
		.o_timer_async(tasync), .o_counter_value(cnt), .o_other_prescaler_reset(opsr), .o_cmp_irq(cirq),
		.o_ovf_irq(oirq)
	);

	atc_osc_model src (.i_run(run), .o_xtal(xtal), .o_ext(extp));

	// ----
	// Bus and compare tasks
	// ----
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checks_done++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic ta, tw, b;
		ta = 1'b0;
		tw = 1'b0;
		b = 1'b0;
		@(posedge clk);
		awaddr <= a;
		wdata <= {24'h00_0000, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		while (!b)
		begin
			@(negedge clk);
			ta = ta | awready;
			tw = tw | wready;
			b = bvalid;
			rsp = bresp;
			@(posedge clk);
			if (ta) awvalid <= 1'b0;
			if (tw) wvalid <= 1'b0;
		end
	endtask : wr

	task automatic rd(input logic [7:0] a);
		logic t, v;
		v = 1'b0;
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		while (!v)
		begin
			@(negedge clk);
			t = arready;
			v = rvalid;
			rdv = rdata[7:0];
			rsp = rresp;
			@(posedge clk);
			if (t) arvalid <= 1'b0;
		end
	endtask : rd

	task automatic rdc(input logic [7:0] a, input logic [7:0] e);
		rd(a);
		chk(rdv, e);
	endtask : rdc

	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask : tick

	task automatic end_sim();
		$display("checks %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : end_sim

	initial
	begin
		repeat (20000) @(posedge clk);
		n_mismatch++;
		end_sim();
	end

	// ----
	// Main sequence
	// ----
	initial
	begin
		rows = '{'{1'b0, 8'h00, 8'h00, 8'h00}, '{1'b0, 8'h04, 8'h00, 8'h00}, '{1'b0, 8'h08, 8'h00, 8'h00},
			'{1'b0, 8'h0C, 8'h00, 8'h00}, '{1'b0, 8'h10, 8'h00, 8'h00}, '{1'b0, 8'h14, 8'h00, 8'h00},
			'{1'b0, 8'h18, 8'h00, 8'h00}, '{1'b0, 8'h1C, 8'h00, 8'h00}, '{1'b1, 8'h04, 8'hFF, 8'h03},
			'{1'b1, 8'h14, 8'hA5, 8'hA5}, '{1'b1, 8'h18, 8'hFF, 8'hC3}, '{1'b1, 8'h1C, 8'h87, 8'h07}};
		nrst = 1'b0;
		awaddr = 8'h00;
		araddr = 8'h00;
		wdata = 32'h0000_0000;
		{awvalid, wvalid, arvalid, sysosc, gie, oack, cack, run} = 8'h00;
		strb = 4'hF;
		n_mismatch = 0;
		checks_done = 0;
		repeat (12) @(posedge clk);
		nrst <= 1'b1;
		tick(2);
		foreach (rows[i])
		begin
			if (rows[i].wr) wr(rows[i].addr, rows[i].data);
			rdc(rows[i].addr, rows[i].exp);
		end
		wr(8'h20, 8'h5A);
		chk({6'h00, rsp}, 8'h02);
		rd(8'h20);
		chk({6'h00, rsp}, 8'h02);
		chk(rdv, 8'h00);
		// Write with byte lane 0 off is answered but ignored
		strb <= 4'hE;
		wr(8'h14, 8'h77);
		strb <= 4'hF;
		chk({6'h00, rsp}, 8'h00);
		rdc(8'h14, 8'hA5);
		// Flags and interrupt requests, timer on the I/O clock
		wr(8'h18, 8'h00);
		wr(8'h14, 8'h10);
		wr(8'h10, 8'h00);
		wr(8'h1C, 8'h01);
		tick(300);
		wr(8'h1C, 8'h00);
		rdc(8'h08, 8'h03);
		wr(8'h04, 8'h03);
		gie <= 1'b1;
		tick(3);
		@(negedge clk);
		chk({6'h00, cirq, oirq}, 8'h03);
		tick(1);
		gie <= 1'b0;
		tick(3);
		@(negedge clk);
		chk({6'h00, cirq, oirq}, 8'h00);
		tick(1);
		gie <= 1'b1;
		oack <= 1'b1;
		tick(1);
		oack <= 1'b0;
		tick(3);
		@(negedge clk);
		chk({6'h00, cirq, oirq}, 8'h02);
		rdc(8'h08, 8'h02);
		wr(8'h08, 8'h02);
		rdc(8'h08, 8'h00);
		// Phase-correct mode: no overflow at the top, one at the bottom
		wr(8'h18, 8'h01);
		wr(8'h10, 8'h01);
		wr(8'h1C, 8'h01);
		wr(8'h08, 8'h03);
		tick(300);
		rd(8'h08);
		chk(rdv & 8'h01, 8'h00);
		tick(250);
		rd(8'h08);
		chk(rdv & 8'h01, 8'h01);
		wr(8'h1C, 8'h00);
		// Compare vector clears only the compare flag, then overflow by one
		cack <= 1'b1;
		tick(1);
		cack <= 1'b0;
		rdc(8'h08, 8'h01);
		wr(8'h08, 8'h01);
		rdc(8'h08, 8'h00);
		// Prescaler reset and hold mode
		wr(8'h0C, 8'h02);
		rdc(8'h0C, 8'h00);
		wr(8'h0C, 8'h83);
		rdc(8'h0C, 8'h83);
		@(negedge clk);
		chk({7'h00, opsr}, 8'h01);
		wr(8'h0C, 8'h00);
		rdc(8'h0C, 8'h00);
		@(negedge clk);
		chk({7'h00, opsr}, 8'h00);
		// Clock source selection
		wr(8'h00, 8'h20);
		rdc(8'h00, 8'h00);
		@(negedge clk);
		chk({5'h00, ebuf, lfrun, tasync}, 8'h00);
		tick(1);
		sysosc <= 1'b1;
		run <= 1'b1;
		wr(8'h00, 8'h40);
		wr(8'h00, 8'h60);
		rdc(8'h00, 8'h60);
		@(negedge clk);
		chk({5'h00, ebuf, lfrun, tasync}, 8'h05);
		wr(8'h00, 8'h20);
		@(negedge clk);
		chk({5'h00, ebuf, lfrun, tasync}, 8'h03);
		// Update-busy handshakes with the timer clock held still
		tick(1);
		run <= 1'b0;
		tick(20);
		wr(8'h18, 8'h00);
		wr(8'h1C, 8'h00);
		wr(8'h14, 8'h44);
		wr(8'h10, 8'h33);
		wr(8'h0C, 8'h02);
		rdc(8'h00, 8'h3B);
		rdc(8'h14, 8'h44);
		rdc(8'h0C, 8'h02);
		run <= 1'b1;
		tick(80);
		rdc(8'h00, 8'h20);
		rdc(8'h10, 8'h33);
		@(negedge clk);
		chk(cnt, 8'h33);
		rdc(8'h0C, 8'h00);
		// Reset in mid-run, asynchronous select on with no timer clock selected
		nrst <= 1'b0;
		tick(2);
		@(negedge clk);
		chk({5'h00, ebuf, lfrun, tasync}, 8'h00);
		chk(cnt, 8'h00);
		tick(1);
		nrst <= 1'b1;
		tick(2);
		rdc(8'h00, 8'h00);
		rdc(8'h14, 8'h00);
		end_sim();
	end
endmodule : async_timer0_control_test
